// ### paf_pkg.sv
`default_nettype none
package paf_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] FSEL_OFFSET = 8'h00;
   localparam logic [7:0] DIR_OFFSET = 8'h04;
   localparam logic [7:0] DATA_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0c;
   localparam int ADDR_W = 8;

   localparam logic [15:0] FSEL_RESET = 16'h0000;
   localparam logic [15:0] FSEL_WR_MASK = 16'h7777;
   localparam logic [15:0] FSEL_RSVD_MASK = 16'h8888;
   localparam logic [3:0] DIR_RESET = 4'h0;
   localparam logic [3:0] DATA_RESET = 4'h0;

   // ****************************************
   // field layout
   // ****************************************
   localparam int FIELD_STRIDE = 4;
   localparam int PIN8_IDX = 0;
   localparam int PIN9_IDX = 1;
   localparam int PIN10_IDX = 2;
   localparam int PIN11_IDX = 3;
   localparam int STATUS_EMU_BIT = 0;
   localparam int STATUS_REDUCED_BIT = 1;

   // ****************************************
   // mode codes
   // ****************************************
   localparam logic [2:0] MODE_GPIO = 3'h0;
   localparam logic [2:0] MODE_TCLK = 3'h1;
   localparam logic [2:0] MODE_ADTRIG = 3'h2;
   localparam logic [2:0] MODE_SERIAL = 3'h6;
   localparam logic [2:0] MODE_OE_REQ = 3'h7;

   // ****************************************
   // bus answers and idle levels
   // ****************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic SERIAL_RX_IDLE = 1'h1;
   localparam logic PERIPH_IN_IDLE = 1'h0;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [2:0] mode_of(input logic [15:0] fsel,
                                          input int pin);
      mode_of = fsel[pin*FIELD_STRIDE +: 3];
   endfunction

   function automatic logic [15:0] strobe16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb,
                                            input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (strb[0]) begin
         v[7:0] = data[7:0];
      end
      if (strb[1]) begin
         v[15:8] = data[15:8];
      end
      strobe16 = v & mask;
   endfunction
endpackage
`default_nettype wire

// ### paf_mux_if.sv
`default_nettype none
interface paf_mux_if;
   logic [15:0] fsel;
   logic [3:0] dir;
   logic [3:0] dout;
   logic emu_active;
   logic [3:0] pin_in;
   logic serial0_tx;
   logic serial2_tx;
   logic tdo;
   logic [3:0] pin_out;
   logic [3:0] pin_oe_n;
   logic serial0_rx;
   logic serial2_rx;
   logic adc_trig;
   logic tclk_c;
   logic tclk_d;
   logic oe_req8;
   logic tdi;

   modport ctrl (
      output fsel, dir, dout, emu_active, pin_in, serial0_tx, serial2_tx,
         tdo,
      input pin_out, pin_oe_n, serial0_rx, serial2_rx, adc_trig, tclk_c,
         tclk_d, oe_req8, tdi
   );
   modport mux (
      input fsel, dir, dout, emu_active, pin_in, serial0_tx, serial2_tx,
         tdo,
      output pin_out, pin_oe_n, serial0_rx, serial2_rx, adc_trig, tclk_c,
         tclk_d, oe_req8, tdi
   );
endinterface
`default_nettype wire

// ### paf_pin_mux.sv
`default_nettype none
module paf_pin_mux (
   paf_mux_if.mux m
);
   logic [2:0] md8;
   logic [2:0] md9;
   logic [2:0] md10;
   logic [2:0] md11;

   // ****************************************
   // pin routing
   // ****************************************
   always_comb begin
      md8 = paf_pkg::mode_of(m.fsel, paf_pkg::PIN8_IDX);
      md9 = paf_pkg::mode_of(m.fsel, paf_pkg::PIN9_IDX);
      md10 = paf_pkg::mode_of(m.fsel, paf_pkg::PIN10_IDX);
      md11 = paf_pkg::mode_of(m.fsel, paf_pkg::PIN11_IDX);
      m.pin_out = m.dout;
      m.pin_oe_n = 4'hf;
      m.serial0_rx = paf_pkg::SERIAL_RX_IDLE;
      m.serial2_rx = paf_pkg::SERIAL_RX_IDLE;
      m.adc_trig = paf_pkg::PERIPH_IN_IDLE;
      m.tclk_c = paf_pkg::PERIPH_IN_IDLE;
      m.tclk_d = paf_pkg::PERIPH_IN_IDLE;
      m.oe_req8 = paf_pkg::PERIPH_IN_IDLE;
      m.tdi = paf_pkg::PERIPH_IN_IDLE;
      // pin 11
      case (md11)
         paf_pkg::MODE_GPIO: m.pin_oe_n[3] = ~m.dir[3];
         paf_pkg::MODE_ADTRIG: m.adc_trig = m.pin_in[3];
         paf_pkg::MODE_SERIAL: begin
            m.pin_out[3] = m.serial0_tx;
            m.pin_oe_n[3] = 1'b0;
         end
         default: m.pin_oe_n[3] = 1'b1;
      endcase
      // pin 10
      case (md10)
         paf_pkg::MODE_GPIO: m.pin_oe_n[2] = ~m.dir[2];
         paf_pkg::MODE_SERIAL: m.serial0_rx = m.pin_in[2];
         default: m.pin_oe_n[2] = 1'b1;
      endcase
      // pin 9
      if (m.emu_active) begin
         m.pin_out[1] = m.tdo;
         m.pin_oe_n[1] = 1'b0;
      end else begin
         case (md9)
            paf_pkg::MODE_GPIO: m.pin_oe_n[1] = ~m.dir[1];
            paf_pkg::MODE_TCLK: m.tclk_d = m.pin_in[1];
            paf_pkg::MODE_SERIAL: begin
               m.pin_out[1] = m.serial2_tx;
               m.pin_oe_n[1] = 1'b0;
            end
            paf_pkg::MODE_OE_REQ: m.oe_req8 = m.pin_in[1];
            default: m.pin_oe_n[1] = 1'b1;
         endcase
      end
      // pin 8
      if (m.emu_active) begin
         m.tdi = m.pin_in[0];
         m.pin_oe_n[0] = 1'b1;
      end else begin
         case (md8)
            paf_pkg::MODE_GPIO: m.pin_oe_n[0] = ~m.dir[0];
            paf_pkg::MODE_TCLK: m.tclk_c = m.pin_in[0];
            paf_pkg::MODE_SERIAL: m.serial2_rx = m.pin_in[0];
            default: m.pin_oe_n[0] = 1'b1;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### paf_top.sv
// Overview of operation
// - reserved bits 15, 11, 7, 3 read zero
// - pin 11: gpio, A/D trigger, serial0 transmit
// - pin 10: gpio or serial0 receive
// - pin 9: gpio, timer D, serial2 tx, enable request
// - pin 8: gpio, timer C, serial2 receive
// - emulator attached forces pin 9 test output
// - emulator attached forces pin 8 test input
// - no emulator override on reduced-memory variants
// - gpio direction from direction register bit
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module paf_top #(
   parameter bit REDUCED_MEMORY = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic emulator_mode_pin_n,
   input wire logic [3:0] port_pin_in,
   output logic [3:0] port_pin_out,
   output logic [3:0] port_pin_oe_n,
   input wire logic serial0_transmit,
   input wire logic serial2_transmit,
   input wire logic test_data_out,
   output logic serial0_receive,
   output logic serial2_receive,
   output logic adc_external_trigger,
   output logic timer_ext_clock_c,
   output logic timer_ext_clock_d,
   output logic output_enable_request_8,
   output logic test_data_in
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic awready;
      logic aw_have;
      logic [7:0] awaddr;
      logic wready;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] fsel;
      logic [3:0] dir;
      logic [3:0] dout;
      logic emu;
      logic [3:0] pin_out;
      logic [3:0] pin_oe_n;
      logic serial0_rx;
      logic serial2_rx;
      logic adc_trig;
      logic tclk_c;
      logic tclk_d;
      logic oe_req8;
      logic tdi;
   } paf_state_t;

   localparam paf_state_t ST_RESET = '{
      awready: 1'b0, aw_have: 1'b0, awaddr: 8'h00, wready: 1'b0,
      w_have: 1'b0, wdata: 32'h0000_0000, wstrb: 4'h0, bvalid: 1'b0,
      bresp: paf_pkg::RESP_OKAY, arready: 1'b0, rvalid: 1'b0,
      rdata: 32'h0000_0000, rresp: paf_pkg::RESP_OKAY,
      fsel: paf_pkg::FSEL_RESET, dir: paf_pkg::DIR_RESET,
      dout: paf_pkg::DATA_RESET, emu: 1'b0, pin_out: 4'h0,
      pin_oe_n: 4'hf, serial0_rx: paf_pkg::SERIAL_RX_IDLE,
      serial2_rx: paf_pkg::SERIAL_RX_IDLE,
      adc_trig: paf_pkg::PERIPH_IN_IDLE, tclk_c: paf_pkg::PERIPH_IN_IDLE,
      tclk_d: paf_pkg::PERIPH_IN_IDLE, oe_req8: paf_pkg::PERIPH_IN_IDLE,
      tdi: paf_pkg::PERIPH_IN_IDLE
   };

   paf_state_t st_reg;
   paf_state_t st_next;
   logic emu_active;
   paf_mux_if mux_bus ();

   // ****************************************
   // pin mux
   // ****************************************
   assign emu_active = !REDUCED_MEMORY && !emulator_mode_pin_n;
   assign mux_bus.fsel = st_reg.fsel;
   assign mux_bus.dir = st_reg.dir;
   assign mux_bus.dout = st_reg.dout;
   assign mux_bus.emu_active = emu_active;
   assign mux_bus.pin_in = port_pin_in;
   assign mux_bus.serial0_tx = serial0_transmit;
   assign mux_bus.serial2_tx = serial2_transmit;
   assign mux_bus.tdo = test_data_out;

   paf_pin_mux u_mux (
      .m(mux_bus.mux)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_next = st_reg;
      st_next.emu = emu_active;
      st_next.pin_out = mux_bus.pin_out;
      st_next.pin_oe_n = mux_bus.pin_oe_n;
      st_next.serial0_rx = mux_bus.serial0_rx;
      st_next.serial2_rx = mux_bus.serial2_rx;
      st_next.adc_trig = mux_bus.adc_trig;
      st_next.tclk_c = mux_bus.tclk_c;
      st_next.tclk_d = mux_bus.tclk_d;
      st_next.oe_req8 = mux_bus.oe_req8;
      st_next.tdi = mux_bus.tdi;
      // write channel
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.aw_have = 1'b1;
         st_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.w_have = 1'b1;
         st_next.wdata = s_axi_wdata;
         st_next.wstrb = s_axi_wstrb;
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
         st_next.aw_have = 1'b0;
         st_next.w_have = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = paf_pkg::RESP_OKAY;
         case (st_reg.awaddr)
            paf_pkg::FSEL_OFFSET: st_next.fsel = paf_pkg::strobe16(
               st_reg.fsel, st_reg.wdata, st_reg.wstrb,
               paf_pkg::FSEL_WR_MASK);
            paf_pkg::DIR_OFFSET: begin
               if (st_reg.wstrb[0]) begin
                  st_next.dir = st_reg.wdata[3:0];
               end
            end
            paf_pkg::DATA_OFFSET: begin
               if (st_reg.wstrb[0]) begin
                  st_next.dout = st_reg.wdata[3:0];
               end
            end
            paf_pkg::STATUS_OFFSET: st_next.bresp = paf_pkg::RESP_OKAY;
            default: st_next.bresp = paf_pkg::RESP_SLVERR;
         endcase
      end
      st_next.awready = !st_next.aw_have && !st_next.bvalid;
      st_next.wready = !st_next.w_have && !st_next.bvalid;
      // read channel
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = paf_pkg::RESP_OKAY;
         st_next.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            paf_pkg::FSEL_OFFSET: st_next.rdata[15:0] =
               st_reg.fsel & paf_pkg::FSEL_WR_MASK;
            paf_pkg::DIR_OFFSET: st_next.rdata[3:0] = st_reg.dir;
            paf_pkg::DATA_OFFSET: st_next.rdata[3:0] = port_pin_in;
            paf_pkg::STATUS_OFFSET: begin
               st_next.rdata[paf_pkg::STATUS_EMU_BIT] = st_reg.emu;
               st_next.rdata[paf_pkg::STATUS_REDUCED_BIT] = REDUCED_MEMORY;
            end
            default: st_next.rresp = paf_pkg::RESP_SLVERR;
         endcase
      end
      st_next.arready = !st_next.rvalid;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready = st_reg.wready;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign port_pin_out = st_reg.pin_out;
   assign port_pin_oe_n = st_reg.pin_oe_n;
   assign serial0_receive = st_reg.serial0_rx;
   assign serial2_receive = st_reg.serial2_rx;
   assign adc_external_trigger = st_reg.adc_trig;
   assign timer_ext_clock_c = st_reg.tclk_c;
   assign timer_ext_clock_d = st_reg.tclk_d;
   assign output_enable_request_8 = st_reg.oe_req8;
   assign test_data_in = st_reg.tdi;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   logic [2:0] md8;
   logic [2:0] md9;
   logic [2:0] md10;
   logic [2:0] md11;
   assign md8 = paf_pkg::mode_of(st_reg.fsel, paf_pkg::PIN8_IDX);
   assign md9 = paf_pkg::mode_of(st_reg.fsel, paf_pkg::PIN9_IDX);
   assign md10 = paf_pkg::mode_of(st_reg.fsel, paf_pkg::PIN10_IDX);
   assign md11 = paf_pkg::mode_of(st_reg.fsel, paf_pkg::PIN11_IDX);

   AST_RSVD_READ: assert property (
      s_axi_arvalid && s_axi_arready
      && s_axi_araddr == paf_pkg::FSEL_OFFSET
      |=> s_axi_rvalid
      && (s_axi_rdata[15:0] & paf_pkg::FSEL_RSVD_MASK) == 16'h0000)
      else $error("reserved select bits read nonzero");

   AST_P11_TX: assert property (
      md11 == 3'h6 |=> !port_pin_oe_n[3]
      && port_pin_out[3] == $past(serial0_transmit))
      else $error("pin 11 not driving serial0 transmit");

   AST_P11_ADC: assert property (
      md11 == 3'h2 |=> port_pin_oe_n[3]
      && adc_external_trigger == $past(port_pin_in[3]))
      else $error("pin 11 not routed to A/D trigger");

   AST_P10_RX: assert property (
      md10 == 3'h6 |=> port_pin_oe_n[2]
      && serial0_receive == $past(port_pin_in[2]))
      else $error("pin 10 not routed to serial0 receive");

   AST_P9_POE: assert property (
      md9 == 3'h7 && emulator_mode_pin_n |=> port_pin_oe_n[1]
      && output_enable_request_8 == $past(port_pin_in[1]))
      else $error("pin 9 not routed to enable request");

   AST_P9_TCLK: assert property (
      md9 == paf_pkg::MODE_TCLK && emulator_mode_pin_n
      |=> timer_ext_clock_d == $past(port_pin_in[1]))
      else $error("pin 9 not routed to timer clock D");

   AST_P9_TX: assert property (
      md9 == paf_pkg::MODE_SERIAL && emulator_mode_pin_n
      |=> !port_pin_oe_n[1]
      && port_pin_out[1] == $past(serial2_transmit))
      else $error("pin 9 not driving serial2 transmit");

   AST_P8_RX: assert property (
      md8 == paf_pkg::MODE_SERIAL && emulator_mode_pin_n
      |=> port_pin_oe_n[0]
      && serial2_receive == $past(port_pin_in[0]))
      else $error("pin 8 not routed to serial2 receive");

   AST_P8_TCLK: assert property (
      md8 == 3'h1 && emulator_mode_pin_n
      |=> timer_ext_clock_c == $past(port_pin_in[0]))
      else $error("pin 8 not routed to timer clock C");

   AST_P9_TDO: assert property (
      !REDUCED_MEMORY && !emulator_mode_pin_n |=> !port_pin_oe_n[1]
      && port_pin_out[1] == $past(test_data_out))
      else $error("pin 9 not forced to test output");

   AST_P8_TDI: assert property (
      !REDUCED_MEMORY && !emulator_mode_pin_n |=> port_pin_oe_n[0]
      && test_data_in == $past(port_pin_in[0]))
      else $error("pin 8 not forced to test input");

   AST_NO_EMU: assert property (
      REDUCED_MEMORY |-> !st_reg.emu && test_data_in == 1'b0)
      else $error("override active on reduced variant");

   AST_GPIO_DIR: assert property (
      md10 == 3'h0 |=> port_pin_oe_n[2] == !$past(st_reg.dir[2]))
      else $error("gpio direction mismatch");

   AST_FSEL_UPD: assert property (
      $changed(st_reg.fsel) |-> $rose(s_axi_bvalid)
      && (st_reg.fsel & paf_pkg::FSEL_RSVD_MASK) == 16'h0000)
      else $error("select changed outside a write");

   COV_EMU: cover property (!emulator_mode_pin_n [*3]);
   COV_WR: cover property (s_axi_bvalid && s_axi_bready);
   COV_RD: cover property (s_axi_rvalid && s_axi_rready);
   COV_TX: cover property (md11 == 3'h6 ##1 md9 == 3'h6);
endmodule
`default_nettype wire

// ### paf_far_model.sv
`default_nettype none
module paf_far_model (
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe_n,
   input wire logic [3:0] ext_level,
   input wire logic [2:0] tx_level,
   output logic [3:0] pad_level,
   output logic serial0_tx,
   output logic serial2_tx,
   output logic tdo
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // pad level: block wins while it drives
   // ****************************************
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pad_level[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
      end
   end
   // ****************************************
   // peripheral drive lines
   // ****************************************
   assign {serial0_tx, serial2_tx, tdo} = tx_level;
endmodule
`default_nettype wire

// ### paf_top_tb_top.sv
`default_nettype none
module paf_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, emulator_mode_pin_n;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, port_pin_in, port_pin_out, port_pin_oe_n;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic serial0_transmit, serial2_transmit, test_data_out;
   logic serial0_receive, serial2_receive, adc_external_trigger;
   logic timer_ext_clock_c, timer_ext_clock_d, output_enable_request_8;
   logic test_data_in;
   logic [3:0] ext_level;
   logic [2:0] tx_level;
   logic [3:0] rm_oe_n;
   logic rm_tdi;
   int n_errors, checks_done;

   paf_top paf_top_i (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .emulator_mode_pin_n,
      .port_pin_in, .port_pin_out, .port_pin_oe_n, .serial0_transmit,
      .serial2_transmit, .test_data_out, .serial0_receive,
      .serial2_receive, .adc_external_trigger, .timer_ext_clock_c,
      .timer_ext_clock_d, .output_enable_request_8, .test_data_in);

   paf_far_model paf_far_model_i (.pin_out(port_pin_out),
      .pin_oe_n(port_pin_oe_n), .ext_level(ext_level),
      .tx_level(tx_level), .pad_level(port_pin_in),
      .serial0_tx(serial0_transmit), .serial2_tx(serial2_transmit),
      .tdo(test_data_out));

   // reduced-memory variant: no emulator override
   paf_top #(.REDUCED_MEMORY(1'b1)) paf_top_rm_i (.core_clk, .rst_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
      .s_axi_rready, .emulator_mode_pin_n, .port_pin_in,
      .port_pin_out(), .port_pin_oe_n(rm_oe_n), .serial0_transmit,
      .serial2_transmit, .test_data_out, .serial0_receive(),
      .serial2_receive(), .adc_external_trigger(), .timer_ext_clock_c(),
      .timer_ext_clock_d(), .output_enable_request_8(),
      .test_data_in(rm_tdi));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
         n_errors++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [1:0] r);
      logic ta, tw, tb;
      tb = 1'b0;
      r = 2'h3;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 200 && !tb; n++) begin
         @(negedge core_clk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
      end
      if (!tb) begin
         n_errors++;
         test_done();
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      logic tr, ta;
      tr = 1'b0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 200 && !tr; n++) begin
         @(negedge core_clk);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) s_axi_rready <= 1'b0;
      end
      if (!tr) begin
         n_errors++;
         test_done();
      end
   endtask

   function automatic logic [14:0] obs();
      return {port_pin_oe_n, port_pin_out & ~port_pin_oe_n,
         serial0_receive, serial2_receive, adc_external_trigger,
         timer_ext_clock_c, timer_ext_clock_d, output_enable_request_8,
         test_data_in};
   endfunction

   task automatic pin_case(input logic [15:0] f, input logic [3:0] ext,
         input logic [2:0] tx, input logic [14:0] e);
      logic [1:0] r;
      wr(paf_pkg::FSEL_OFFSET, {16'h0000, f}, 4'h3, r);
      ext_level <= ext;
      tx_level <= tx;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk(obs(), {17'h00000, e});
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      logic [31:0] v;
      logic [1:0] r;
      @(negedge core_clk);
      chk(obs(), {4'hf, 4'h0, 7'h60});
      rd(paf_pkg::FSEL_OFFSET, v, r);
      chk(v, {16'h0000, paf_pkg::FSEL_RESET});
      chk(r, paf_pkg::RESP_OKAY);
   endtask

   task automatic t_fsel_bits();
      logic [31:0] v;
      logic [1:0] r;
      wr(paf_pkg::FSEL_OFFSET, 32'hffffffff, 4'hf, r);
      rd(paf_pkg::FSEL_OFFSET, v, r);
      chk(v, 32'h00007777);
      wr(paf_pkg::FSEL_OFFSET, 32'h00000000, 4'h2, r);
      rd(paf_pkg::FSEL_OFFSET, v, r);
      chk(v, 32'h00000077);
      wr(paf_pkg::FSEL_OFFSET, 32'h00000000, 4'hf, r);
   endtask

   task automatic t_unmapped();
      logic [31:0] v;
      logic [1:0] r;
      wr(8'h10, 32'h00006666, 4'hf, r);
      chk(r, paf_pkg::RESP_SLVERR);
      rd(8'h10, v, r);
      chk(r, paf_pkg::RESP_SLVERR);
      chk(v, 32'h00000000);
      rd(paf_pkg::FSEL_OFFSET, v, r);
      chk(v, 32'h00000000);
   endtask

   task automatic t_pins();
      pin_case(16'h6611, 4'h3, 3'h4, {4'h7, 4'h8, 7'h2c});
      pin_case(16'h2076, 4'ha, 3'h0, {4'hf, 4'h0, 7'h52});
      pin_case(16'h0060, 4'h0, 3'h2, {4'hd, 4'h2, 7'h60});
   endtask

   task automatic t_emulator();
      logic [31:0] v;
      logic [1:0] r;
      @(posedge core_clk);
      emulator_mode_pin_n <= 1'b0;
      pin_case(16'h0060, 4'h1, 3'h1, {4'hd, 4'h2, 7'h61});
      chk({rm_oe_n, rm_tdi}, {4'hd, 1'b0});
      rd(paf_pkg::STATUS_OFFSET, v, r);
      chk(v, 32'h00000001);
      emulator_mode_pin_n <= 1'b1;
   endtask

   task automatic t_gpio();
      logic [31:0] v;
      logic [1:0] r;
      wr(paf_pkg::DIR_OFFSET, 32'h00000005, 4'h1, r);
      wr(paf_pkg::DATA_OFFSET, 32'h00000005, 4'h1, r);
      pin_case(16'h0000, 4'h0, 3'h0, {4'ha, 4'h5, 7'h60});
      rd(paf_pkg::DATA_OFFSET, v, r);
      chk(v, 32'h00000005);
   endtask

   initial begin
      n_errors = 0;
      checks_done = 0;
      rst_n = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      emulator_mode_pin_n = 1'b1;
      ext_level = 4'h0;
      tx_level = 3'h0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_fsel_bits();
      t_unmapped();
      t_pins();
      t_emulator();
      t_gpio();
      test_done();
   end
endmodule
`default_nettype wire
